// ==== src/cfg_load_pkg.sv ====
// constants shared by both ends of the peripheral configuration link
package cfg_load_pkg;
    // mode-select codes, ordered hi, mid, lo
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_SYNC_PERIPH = 3'h3;
    localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
    // stream framing
    localparam logic [3:0] PREAMBLE = 4'h2;
    localparam int LEN_W = 24;
    localparam logic [4:0] LEN_BITS = 5'h18;
    localparam logic [15:0] OWN_FRAME_BITS = 16'h0040;
    localparam logic [4:0] POWERUP_CLOCKS = 5'h10;
    // link timing, in config_clock periods
    localparam logic [2:0] BYTE_EDGES = 3'h0;
    localparam logic [1:0] BUSY_MIN_CYC = 2'h2;
    localparam int BUSY_MAX_CYC = 9;
    localparam logic [4:0] TAIL_EDGES = 5'h0A;
    localparam logic [4:0] CHAIN_DEVICES = 5'h01;
    localparam logic [4:0] TAIL_TOTAL = TAIL_EDGES + CHAIN_DEVICES;
    localparam logic [1:0] RELEASE_CYCLES = 2'h2;
    // host clock divider, in clk_i cycles
    localparam logic [1:0] CONFIG_CLOCK_HALF_CLKS = 2'h2;
    localparam logic [4:0] CONFIG_CLOCK_PERIOD_CLKS = 5'h04;
    localparam logic [4:0] ASYNC_GAP_CLKS = 5'h0C;
    // host register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] DATA_OFF = 8'h08;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ASYNC_BIT = 1;
    localparam int CTRL_FINISH_BIT = 2;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
endpackage

// ==== src/cfg_link_if.sv ====
// pin-level link between the configuring host and the device
`timescale 1ns/1ps
interface cfg_link_if;
    logic config_clock;
    logic [7:0] cfg_data;
    logic mode_select_hi;
    logic mode_select_mid;
    logic mode_select_lo;
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic write_strobe_n;
    logic read_strobe_n;
    logic init_status;
    logic ready_out;
    logic ready_oe_n;
    logic ready_line;
    logic chain_out;

    // weak pull-up while the device leaves the pin undriven
    assign ready_line = ready_oe_n ? 1'b1 : ready_out;

    modport device (
        input config_clock, cfg_data, mode_select_hi, mode_select_mid, mode_select_lo,
        input chip_select_low_active, chip_select_high_active, write_strobe_n, read_strobe_n,
        output init_status, ready_out, ready_oe_n, chain_out
    );
    modport host (
        output config_clock, cfg_data, mode_select_hi, mode_select_mid, mode_select_lo,
        output chip_select_low_active, chip_select_high_active, write_strobe_n, read_strobe_n,
        input init_status, ready_line, chain_out
    );
endinterface

// ==== src/cfg_device_end.sv ====
// device end: byte-wide peripheral configuration loader on config_clock
`timescale 1ns/1ps
// Overview of operation
// - host clocks, sets first byte before edge
// - capture a byte every eighth edge
// - acknowledge high one period at capture
// - ready pin undriven until init rises
// - forward preamble, length and overflow on chain
// - chain output lags 1.5, falling edge
// - host gives 10 plus chain tail edges
// - mode 011 selects synchronous loading
// - host waits for init high
// - write needs cs0,ws low, rs,cs1 high
// - busy low 2 to 9 periods
// - double-buffered parallel-to-serial converter
// - host holds write until ready high
// - data captured while strobe still active
// - byte start waits for previous byte
// - on 0010 take and forward length, then hold chain high for own bits
// - start-up when clock count equals length
// - release outputs two cycles after end
module cfg_device_end (
    // link to host
    cfg_link_if.device link,
    // reset
    input wire logic reset_i,
    // user side
    output logic init_done_o,
    output logic config_done_o,
    output logic user_release_o,
    output logic [cfg_load_pkg::LEN_W-1:0] length_count_o
);
    import cfg_load_pkg::*;

    typedef enum logic [1:0] {HDR_HUNT, HDR_LENGTH, HDR_OWN, HDR_PASS} hdr_state_t;

    logic [2:0] mode_meta_reg;
    logic [2:0] mode_sync_reg;
    logic [3:0] strobe_meta_reg;
    logic [3:0] strobe_sync_reg;
    logic [2:0] mode_reg;
    logic [4:0] powerup_reg;
    logic init_reg;
    logic write_seen_reg;
    logic [7:0] hold_reg;
    logic hold_full_reg;
    logic [1:0] busy_reg;
    logic [2:0] byte_cnt_reg;
    logic [6:0] shift_reg;
    logic [2:0] shift_left_reg;
    logic ser_bit_reg;
    logic ser_valid_reg;
    logic ready_reg;
    logic ready_oe_n_reg;
    logic chain_pre_reg;
    logic chain_reg;
    logic [2:0] hist_reg;
    hdr_state_t hdr_reg;
    logic [15:0] field_cnt_reg;
    logic [LEN_W-1:0] length_reg;
    logic [LEN_W-1:0] clock_cnt_reg;
    logic done_reg;
    logic [1:0] release_cnt_reg;
    logic release_reg;

    // init rises on the last power-up edge; the host stops the clock right after it
    wire init_next = init_reg | (powerup_reg == POWERUP_CLOCKS - 5'h01);
    wire is_sync = (mode_reg == MODE_SYNC_PERIPH);
    wire is_async = (mode_reg == MODE_ASYNC_PERIPH);
    wire write_qual = init_reg & is_async & ~strobe_sync_reg[3] & strobe_sync_reg[2]
        & ~strobe_sync_reg[1] & strobe_sync_reg[0];
    // overlapping write into a full holding stage is refused
    wire accept = write_qual & ~write_seen_reg & ~hold_full_reg;
    wire capture = init_reg & is_sync & (byte_cnt_reg == BYTE_EDGES);
    wire load_async = is_async & hold_full_reg & (shift_left_reg == 3'h0);
    wire load_shift = capture | load_async;
    wire [7:0] load_byte = capture ? link.cfg_data : hold_reg;
    wire hold_full_next = accept | (hold_full_reg & ~load_async);
    wire [1:0] busy_next = accept ? BUSY_MIN_CYC : ((busy_reg != 2'h0) ? busy_reg - 2'h1 : 2'h0);
    wire ready_async = ~hold_full_next & (busy_next == 2'h0);
    wire ready_next = is_sync ? capture : (is_async ? ready_async : 1'b1);
    wire [3:0] window = {hist_reg, ser_bit_reg};
    wire header_seen = (hdr_reg == HDR_OWN) | (hdr_reg == HDR_PASS);
    wire length_match = header_seen & ~done_reg & (clock_cnt_reg == length_reg);

    // pin synchronisers and power-up clearing
    always_ff @(posedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            mode_meta_reg <= 3'h0;
            mode_sync_reg <= 3'h0;
            strobe_meta_reg <= 4'hF;
            strobe_sync_reg <= 4'hF;
            mode_reg <= MODE_NONE;
            powerup_reg <= 5'h00;
            init_reg <= 1'b0;
            ready_oe_n_reg <= 1'b1;
        end else begin
            mode_meta_reg <= {link.mode_select_hi, link.mode_select_mid, link.mode_select_lo};
            mode_sync_reg <= mode_meta_reg;
            strobe_meta_reg <= {link.chip_select_low_active, link.chip_select_high_active,
                                link.write_strobe_n, link.read_strobe_n};
            strobe_sync_reg <= strobe_meta_reg;
            // mode frozen once init rises
            if (!init_reg) begin
                mode_reg <= mode_sync_reg;
            end
            if (!init_next) begin
                powerup_reg <= powerup_reg + 5'h01;
            end
            init_reg <= init_next;
            ready_oe_n_reg <= ~init_next;
        end
    end

    // holding stage in front of shifter
    always_ff @(posedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            write_seen_reg <= 1'b0;
            hold_reg <= 8'h00;
            hold_full_reg <= 1'b0;
            busy_reg <= 2'h0;
            ready_reg <= 1'b1;
        end else begin
            write_seen_reg <= write_qual;
            if (accept) begin
                hold_reg <= link.cfg_data;
            end
            hold_full_reg <= hold_full_next;
            busy_reg <= busy_next;
            ready_reg <= ready_next;
        end
    end

    always_ff @(posedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            byte_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            shift_left_reg <= 3'h0;
            ser_bit_reg <= 1'b1;
            ser_valid_reg <= 1'b0;
        end else begin
            byte_cnt_reg <= (init_reg & is_sync) ? byte_cnt_reg + 3'h1 : 3'h0;
            if (load_shift) begin
                ser_bit_reg <= load_byte[7];
                shift_reg <= load_byte[6:0];
                shift_left_reg <= 3'h7;
                ser_valid_reg <= 1'b1;
            end else if (shift_left_reg != 3'h0) begin
                ser_bit_reg <= shift_reg[6];
                shift_reg <= {shift_reg[5:0], 1'b0};
                shift_left_reg <= shift_left_reg - 3'h1;
                ser_valid_reg <= 1'b1;
            end else begin
                ser_bit_reg <= 1'b1;
                ser_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            hist_reg <= 3'h7;
            hdr_reg <= HDR_HUNT;
            field_cnt_reg <= 16'h0000;
            length_reg <= '0;
            chain_pre_reg <= 1'b1;
        end else begin
            chain_pre_reg <= (hdr_reg == HDR_OWN) | ~ser_valid_reg | ser_bit_reg;
            if (ser_valid_reg) begin
                hist_reg <= window[2:0];
                case (hdr_reg)
                    HDR_HUNT: begin
                        if (window == PREAMBLE) begin
                            hdr_reg <= HDR_LENGTH;
                            field_cnt_reg <= 16'h0000;
                        end
                    end
                    HDR_LENGTH: begin
                        length_reg <= {length_reg[LEN_W-2:0], ser_bit_reg};
                        if (field_cnt_reg == {11'h000, LEN_BITS - 5'h01}) begin
                            hdr_reg <= HDR_OWN;
                            field_cnt_reg <= 16'h0000;
                        end else begin
                            field_cnt_reg <= field_cnt_reg + 16'h0001;
                        end
                    end
                    HDR_OWN: begin
                        if (field_cnt_reg == OWN_FRAME_BITS - 16'h0001) begin
                            hdr_reg <= HDR_PASS;
                        end else begin
                            field_cnt_reg <= field_cnt_reg + 16'h0001;
                        end
                    end
                    default: begin
                        hdr_reg <= HDR_PASS;
                    end
                endcase
            end
        end
    end

    always_ff @(negedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            chain_reg <= 1'b1;
        end else begin
            chain_reg <= chain_pre_reg;
        end
    end

    always_ff @(posedge link.config_clock or posedge reset_i) begin
        if (reset_i) begin
            clock_cnt_reg <= '0;
            done_reg <= 1'b0;
            release_cnt_reg <= 2'h0;
            release_reg <= 1'b0;
        end else begin
            if (init_reg & ~done_reg) begin
                clock_cnt_reg <= clock_cnt_reg + 24'h000001;
            end
            if (length_match) begin
                done_reg <= 1'b1;
            end
            if (done_reg & ~release_reg) begin
                release_cnt_reg <= release_cnt_reg + 2'h1;
                if (release_cnt_reg == RELEASE_CYCLES - 2'h1) begin
                    release_reg <= 1'b1;
                end
            end
        end
    end

    assign link.init_status = init_reg;
    assign link.ready_out = ready_reg;
    assign link.ready_oe_n = ready_oe_n_reg;
    assign link.chain_out = chain_reg;
    assign init_done_o = init_reg;
    assign config_done_o = done_reg;
    assign user_release_o = release_reg;
    assign length_count_o = length_reg;
endmodule // cfg_device_end

// ==== src/cfg_host_end.sv ====
// host end: apb-driven configuration loader that makes config_clock
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module cfg_host_end (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cfg_load_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // link to device
    cfg_link_if.host link
);
    import cfg_load_pkg::*;

    typedef enum logic [3:0] {H_IDLE, H_POWERUP, H_WAIT_INIT, H_SYNC, H_ASYNC_IDLE, H_ASYNC_LOW,
        H_ASYNC_HIGH, H_ASYNC_HOLD, H_ASYNC_GAP, H_TAIL, H_DONE} host_state_t;

    host_state_t state_reg;
    logic init_meta_reg, init_sync_reg, ready_meta_reg, ready_sync_reg;
    logic [1:0] phase_reg;
    logic config_clock_reg;
    logic [4:0] edge_cnt_reg;
    logic [2:0] bit_cnt_reg;
    logic loaded_reg;
    logic [4:0] wait_cnt_reg;
    logic [7:0] buf_reg;
    logic buf_full_reg;
    logic async_reg, finish_reg;
    logic [7:0] data_reg;
    logic [2:0] mode_pins_reg;
    logic cs_low_reg, write_n_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    wire setup_rd = psel_i & ~penable_i & ~pwrite_i;
    wire access_wr = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = (paddr_i == CTRL_OFF);
    wire hit_status = (paddr_i == STATUS_OFF);
    wire hit_data = (paddr_i == DATA_OFF);
    wire mapped = hit_ctrl | hit_status | hit_data;
    wire start_wr = access_wr & hit_ctrl & pwdata_i[CTRL_START_BIT] & (state_reg == H_IDLE);
    wire data_wr = access_wr & hit_data & ~buf_full_reg;
    wire sync_idle = ~config_clock_reg & (bit_cnt_reg == 3'h0) & ~loaded_reg;
    wire in_async = (state_reg == H_ASYNC_IDLE) | (state_reg == H_ASYNC_LOW) | (state_reg == H_ASYNC_HIGH)
        | (state_reg == H_ASYNC_HOLD) | (state_reg == H_ASYNC_GAP);
    // clock stops only while low: after power-up, between sync bytes, after the tail
    wire run = ((state_reg == H_POWERUP) & (config_clock_reg | (edge_cnt_reg != POWERUP_CLOCKS)))
        | ((state_reg == H_SYNC) & ~sync_idle) | in_async
        | ((state_reg == H_TAIL) & (config_clock_reg | (edge_cnt_reg != TAIL_TOTAL)));
    wire phase_end = run & (phase_reg == CONFIG_CLOCK_HALF_CLKS - 2'h1);
    wire rise = phase_end & ~config_clock_reg;
    wire consume = ((state_reg == H_SYNC) & sync_idle & buf_full_reg & ~rise)
        | ((state_reg == H_ASYNC_IDLE) & buf_full_reg);
    wire [31:0] status_word = {28'h0000000, (state_reg != H_IDLE) & (state_reg != H_DONE),
        state_reg == H_DONE, ~buf_full_reg, init_sync_reg};
    wire [31:0] ctrl_word = {29'h00000000, finish_reg, async_reg, 1'b0};
    wire [31:0] read_word = hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h00000000);

    // apb register file
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            async_reg <= 1'b0;
            finish_reg <= 1'b0;
            buf_reg <= 8'h00;
            buf_full_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (psel_i & ~penable_i) begin
                pslverr_reg <= ~mapped;
            end
            if (setup_rd) begin
                prdata_reg <= read_word;
            end
            if (access_wr & hit_ctrl) begin
                finish_reg <= pwdata_i[CTRL_FINISH_BIT];
                if (state_reg == H_IDLE) begin
                    async_reg <= pwdata_i[CTRL_ASYNC_BIT];
                end
            end
            // a full buffer refuses new bytes
            if (data_wr) begin
                buf_reg <= pwdata_i[7:0];
            end
            buf_full_reg <= data_wr | (buf_full_reg & ~consume);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            init_meta_reg <= 1'b0;
            init_sync_reg <= 1'b0;
            ready_meta_reg <= 1'b1;
            ready_sync_reg <= 1'b1;
            phase_reg <= 2'h0;
            config_clock_reg <= 1'b0;
        end else begin
            init_meta_reg <= link.init_status;
            init_sync_reg <= init_meta_reg;
            ready_meta_reg <= link.ready_line;
            ready_sync_reg <= ready_meta_reg;
            phase_reg <= (run & ~phase_end) ? phase_reg + 2'h1 : 2'h0;
            if (phase_end) begin
                config_clock_reg <= ~config_clock_reg;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= H_IDLE;
            edge_cnt_reg <= 5'h00;
            bit_cnt_reg <= 3'h0;
            loaded_reg <= 1'b0;
            wait_cnt_reg <= 5'h00;
            data_reg <= 8'h00;
            mode_pins_reg <= MODE_NONE;
            cs_low_reg <= 1'b1;
            write_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    edge_cnt_reg <= 5'h00;
                    if (start_wr) begin
                        mode_pins_reg <= pwdata_i[CTRL_ASYNC_BIT] ? MODE_ASYNC_PERIPH : MODE_SYNC_PERIPH;
                        state_reg <= H_POWERUP;
                    end
                end
                H_POWERUP: begin
                    if (rise) begin
                        edge_cnt_reg <= edge_cnt_reg + 5'h01;
                    end else if (~run) begin
                        state_reg <= H_WAIT_INIT;
                    end
                end
                H_WAIT_INIT: begin
                    if (init_sync_reg) begin
                        state_reg <= async_reg ? H_ASYNC_IDLE : H_SYNC;
                    end
                end
                H_SYNC: begin
                    edge_cnt_reg <= 5'h00;
                    if (rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        loaded_reg <= 1'b0;
                    end else if (sync_idle & buf_full_reg) begin
                        data_reg <= buf_reg;
                        loaded_reg <= 1'b1;
                    end else if (sync_idle & finish_reg) begin
                        state_reg <= H_TAIL;
                    end
                end
                H_ASYNC_IDLE: begin
                    edge_cnt_reg <= 5'h00;
                    if (buf_full_reg) begin
                        data_reg <= buf_reg;
                        cs_low_reg <= 1'b0;
                        write_n_reg <= 1'b0;
                        state_reg <= H_ASYNC_LOW;
                    end else if (finish_reg) begin
                        state_reg <= H_TAIL;
                    end
                end
                H_ASYNC_LOW: begin
                    if (~ready_sync_reg) begin
                        state_reg <= H_ASYNC_HIGH;
                    end
                end
                H_ASYNC_HIGH: begin
                    wait_cnt_reg <= 5'h00;
                    if (ready_sync_reg) begin
                        state_reg <= H_ASYNC_HOLD;
                    end
                end
                H_ASYNC_HOLD: begin
                    wait_cnt_reg <= wait_cnt_reg + 5'h01;
                    if (wait_cnt_reg == CONFIG_CLOCK_PERIOD_CLKS - 5'h01) begin
                        cs_low_reg <= 1'b1;
                        write_n_reg <= 1'b1;
                        wait_cnt_reg <= 5'h00;
                        state_reg <= H_ASYNC_GAP;
                    end
                end
                H_ASYNC_GAP: begin
                    // gap lets the device see the strobe end
                    wait_cnt_reg <= wait_cnt_reg + 5'h01;
                    if (wait_cnt_reg == ASYNC_GAP_CLKS - 5'h01) begin
                        state_reg <= H_ASYNC_IDLE;
                    end
                end
                H_TAIL: begin
                    if (rise) begin
                        edge_cnt_reg <= edge_cnt_reg + 5'h01;
                    end else if (~run) begin
                        state_reg <= H_DONE;
                    end
                end
                default: begin
                    state_reg <= H_DONE;
                end
            endcase
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign link.config_clock = config_clock_reg;
    assign link.cfg_data = data_reg;
    assign link.mode_select_hi = mode_pins_reg[2];
    assign link.mode_select_mid = mode_pins_reg[1];
    assign link.mode_select_lo = mode_pins_reg[0];
    assign link.chip_select_low_active = cs_low_reg;
    assign link.chip_select_high_active = 1'b1;
    assign link.write_strobe_n = write_n_reg;
    assign link.read_strobe_n = 1'b1;
endmodule // cfg_host_end

// ==== tb/cfg_link_chk.sv ====
// assertions on the configuration link pins
`timescale 1ns/1ps
module cfg_link_chk (
    // link pins
    input wire logic config_clock,
    input wire logic reset_i,
    input wire logic mode_select_hi,
    input wire logic mode_select_mid,
    input wire logic mode_select_lo,
    input wire logic chip_select_low_active,
    input wire logic chip_select_high_active,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic init_status,
    input wire logic ready_out,
    input wire logic ready_oe_n,
    input wire logic chain_out
);
    import cfg_load_pkg::*;
    wire [2:0] mode_w = {mode_select_hi, mode_select_mid, mode_select_lo};
    wire sync_w = mode_w == MODE_SYNC_PERIPH;
    wire busy_w = mode_w == MODE_ASYNC_PERIPH && !ready_oe_n;
    wire ack_w = ready_out && !ready_oe_n;
    logic chain_rise_reg;
    // value seen at the rising edge, compared in the high phase
    always_ff @(posedge config_clock or posedge reset_i)
        if (reset_i) chain_rise_reg <= 1'b1;
        else chain_rise_reg <= chain_out;
    default clocking @(posedge config_clock); endclocking
    default disable iff (reset_i);
    AST_READY_WEAK: assert property (!init_status |-> ready_oe_n)
        else $error("ready driven before init");
    AST_ACK_ONE: assert property (sync_w && ack_w |=> !ready_out)
        else $error("acknowledge longer than one period");
    AST_ACK_GAP: assert property (sync_w && $rose(ack_w) |=> !ready_out [*7])
        else $error("byte capture spacing not eight edges");
    AST_CHAIN_FALL: assert property (@(negedge config_clock) chain_out == chain_rise_reg)
        else $error("chain output moved off the falling edge");
    AST_WRITE_QUAL: assert property (busy_w && $fell(ready_out) |-> !write_strobe_n
        && !chip_select_low_active && read_strobe_n && chip_select_high_active)
        else $error("busy without a qualified write");
    AST_BUSY_MIN: assert property (busy_w && $fell(ready_out) |=> !ready_out)
        else $error("busy shorter than two periods");
    AST_BUSY_MAX: assert property (busy_w && $fell(ready_out) |-> ##[2:9] ready_out)
        else $error("busy longer than nine periods");
    AST_CHAIN_IDLE: assert property (!init_status |-> chain_out)
        else $error("chain output not high before init");
endmodule // cfg_link_chk

// ==== tb/tb_top.sv ====
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
    import cfg_load_pkg::*;
    typedef struct packed {logic [7:0] a; logic e;} row_t;
    localparam logic [103:0] EXP_CHAIN = {8'hF2, 24'h000064, {64{1'b1}}, 8'hA5};
    row_t rows [0:4] = '{'{CTRL_OFF, 1'b0}, '{STATUS_OFF, 1'b0}, '{8'h0C, 1'b1}, '{8'h40, 1'b1}, '{8'hFC, 1'b1}};
    logic clk_i = 0, reset_i = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, init_done, cfg_done, urel;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [23:0] len_cnt;
    logic cs_bits [0:127];
    int tests_run = 0, n_errors = 0, k = 0, rel_cnt = 0;
    cfg_link_if lk();
    cfg_host_end u_cfg_host_end(.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .link(lk.host));
    cfg_device_end u_cfg_device_end(.link(lk.device), .reset_i(reset_i), .init_done_o(init_done),
        .config_done_o(cfg_done), .user_release_o(urel), .length_count_o(len_cnt));
    cfg_link_chk u_cfg_link_chk(.config_clock(lk.config_clock), .reset_i(reset_i),
        .mode_select_hi(lk.mode_select_hi), .mode_select_mid(lk.mode_select_mid),
        .mode_select_lo(lk.mode_select_lo), .chip_select_low_active(lk.chip_select_low_active),
        .chip_select_high_active(lk.chip_select_high_active), .write_strobe_n(lk.write_strobe_n),
        .read_strobe_n(lk.read_strobe_n), .init_status(lk.init_status), .ready_out(lk.ready_out),
        .ready_oe_n(lk.ready_oe_n), .chain_out(lk.chain_out));
    always #20 clk_i = ~clk_i;
    // chain bits as the next device samples them, from the first acknowledge on
    always @(posedge lk.config_clock) begin
        if (k > 0 || (lk.ready_out === 1'b1 && lk.ready_oe_n === 1'b0)) begin
            if (k < 128) cs_bits[k] <= lk.chain_out;
            k <= k + 1;
        end
        if (cfg_done === 1'b1 && urel === 1'b0) rel_cnt <= rel_cnt + 1;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin n_errors++; final_report; end
        rd = prdata;
        psel <= 0; penable <= 0;
    endtask
    // bounded status poll; a dead link ends the run
    task automatic wait_stat(input int b);
        int i;
        for (i = 0; i < 3000; i++) begin
            apb(0, STATUS_OFF, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        if (i == 3000) begin n_errors++; final_report; end
    endtask
    task automatic do_reset;
        reset_i <= 1; rel_cnt = 0;
        repeat (4) @(posedge clk_i);
        `CHK(lk.ready_line, 1'b1)
        `CHK({lk.chain_out, lk.init_status, lk.config_clock, pready}, 4'h8)
        reset_i <= 0;
    endtask
    // preamble, length 100, 64 own bits, one overflow byte
    task automatic load(input logic as);
        logic [103:0] s;
        s = {8'hF2, 24'h000064, {8{8'h3C}}, 8'hA5};
        apb(1, CTRL_OFF, {30'h0, as, 1'b1});
        wait_stat(STAT_INIT_BIT);
        `CHK({lk.mode_select_hi, lk.mode_select_mid, lk.mode_select_lo}, as ? MODE_ASYNC_PERIPH : MODE_SYNC_PERIPH)
        for (int j = 0; j < 13; j++) begin
            wait_stat(STAT_EMPTY_BIT);
            apb(1, DATA_OFF, {24'h0, s[103 - 8 * j -: 8]});
        end
        apb(1, CTRL_OFF, {29'h0, 1'b1, as, 1'b0});
        wait_stat(STAT_DONE_BIT);
        `CHK(len_cnt, 24'h000064)
        `CHK({cfg_done, urel}, 2'h3)
        `CHK(rel_cnt, 2)
    endtask
    initial begin
        do_reset;
        foreach (rows[i]) begin
            apb(0, rows[i].a, 32'h0);
            `CHK(pslverr, rows[i].e)
        end
        $display("test register map done");
        load(1'b0);
        for (int j = 0; j < 104; j++) `CHK(cs_bits[j + 1], EXP_CHAIN[103 - j])
        $display("test synchronous load done");
        do_reset;
        load(1'b1);
        $display("test asynchronous load done");
        final_report;
    end
endmodule // tb_top
